// ===== lvc_vendor_ctrl.v
// vendor feature control register of the serial-bus link controller
`timescale 1ns/10ps
`include "lvc_defines.vh"

// Overview of operation
// - bit 21 turns the bus holders on; reset value zero.
// - bit 20 makes power-management capability structures visible.
// - bit 19 picks test pin source: nand tree or ram self-test.
// - bit 18 puts the eeprom interface into fast test timing.
// - bits 17:16 select how enhancement enable combines with modifiers.
// - bit 14 mirrors host-control program-phy enable.
// - bit 13 mirrors host-control phy enhancement enable.
// - bit 12 makes the link speed field ignore writes.
// - bit 11 disables the cycle-master absence detector.
// - with force bit set, detector disable changes nothing.
// - bit 10 forces the no-cycle-master condition.
// - 255 consecutive lost cycles conclude absence; good cycle restarts count.
// - bit 9 modifies the ack concatenation enable.
// - bit 7 modifies ack acceleration; enabled means no lost medium on handshake.
// - bit 6 modifies the multispeed concatenation enable.
// - bit 5 modifies the idle insert enable after grant.
// - register loads from the serial eeprom as well as host writes.
// - modes 00/11 xor, 01 and, 10 or.
module lvc_vendor_ctrl #(
   parameter [7:0] LOST_LIMIT = `LVC_LOST_LIMIT
) (
   // clock and reset
   input  wire        core_clk_i,
   input  wire        nrst_i,
   // host access through the vendor register window
   input  wire        vrw_sel_i,
   input  wire [5:0]  vrw_addr_i,
   input  wire        vrw_wr_i,
   input  wire [3:0]  vrw_be_i,
   input  wire [31:0] vrw_wdata_i,
   output reg  [31:0] vrw_rdata_o,
   // serial eeprom configuration load
   input  wire        ee_load_i,
   input  wire [31:0] ee_data_i,
   // standard host control register mirrors
   input  wire        host_prog_wr_i,
   input  wire        host_prog_val_i,
   input  wire        host_enh_wr_i,
   input  wire        host_enh_val_i,
   output wire        host_ctrl_phy_program_enable_o,
   output wire        host_ctrl_phy_enhance_enable_o,
   // bus options link speed field
   input  wire        spd_wr_i,
   input  wire [2:0]  spd_wdata_i,
   output reg  [2:0]  link_speed_field_o,
   // cycle events from the link
   input  wire        cycle_done_i,
   input  wire        cycle_lost_i,
   input  wire        handshake_rx_i,
   // test pin sources
   input  wire        nand_tree_i,
   input  wire        ram_bist_status_i,
   // feature outputs
   output wire        bus_holder_enable_o,
   output wire        pm_capability_visible_o,
   output reg         test_output_pin_o,
   output wire        fast_eeprom_test_o,
   output wire        master_absent_o,
   output wire        ack_concat_en_o,
   output wire        ack_accel_en_o,
   output wire        multispeed_en_o,
   output wire        idle_insert_en_o,
   output wire        medium_lost_o
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   reg  [31:0] vfc_r;
   reg  [31:0] vfc_nxt;
   reg  [2:0]  nand_sync_r;
   reg  [2:0]  bist_sync_r;
   wire        det_absent;
   wire        host_wr;
   wire [31:0] be_mask;

   // byte enables widened to a bit mask, writable bits only
   function [31:0] lvc_be_mask;
      input [3:0] be;
      begin
         lvc_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & `LVC_VFC_WMASK;
      end
   endfunction

   assign host_wr = vrw_sel_i & vrw_wr_i & (vrw_addr_i == `LVC_VFC_OFFSET);
   assign be_mask = lvc_be_mask(vrw_be_i);

   // ----------------------------------------------------------------
   // next register value
   // ----------------------------------------------------------------
   // order: eeprom load, host write, mirror writes, detector set; the
   // detector set comes last so an absence event is never lost to a clear
   always @* begin
      vfc_nxt = vfc_r;
      if (ee_load_i) begin
         vfc_nxt = ee_data_i & `LVC_VFC_WMASK;
      end
      if (host_wr) begin
         vfc_nxt = (vfc_nxt & ~be_mask) | (vrw_wdata_i & be_mask);
      end
      if (host_prog_wr_i) begin
         vfc_nxt[`LVC_BIT_PROG_MIR] = host_prog_val_i;
      end
      if (host_enh_wr_i) begin
         vfc_nxt[`LVC_BIT_ENH_MIR] = host_enh_val_i;
      end
      if (det_absent) begin
         vfc_nxt[`LVC_BIT_FORCE_ABS] = 1'b1;
      end
   end

   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         vfc_r <= `LVC_VFC_RESET;
      end else begin
         vfc_r <= vfc_nxt;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // unmapped offsets read zero; reserved bits never store so read zero
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         vrw_rdata_o <= 32'h0000_0000;
      end else if (vrw_sel_i && !vrw_wr_i) begin
         vrw_rdata_o <= (vrw_addr_i == `LVC_VFC_OFFSET) ? vfc_r : 32'h0000_0000;
      end
   end

   // both locations read the same flop, so they cannot disagree
   assign host_ctrl_phy_program_enable_o = vfc_r[`LVC_BIT_PROG_MIR];
   assign host_ctrl_phy_enhance_enable_o = vfc_r[`LVC_BIT_ENH_MIR];

   // ----------------------------------------------------------------
   // link speed field with write protect
   // ----------------------------------------------------------------
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         link_speed_field_o <= 3'h0;
      end else if (spd_wr_i && !vfc_r[`LVC_BIT_SPD_WP]) begin
         link_speed_field_o <= spd_wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // static feature controls
   // ----------------------------------------------------------------
   assign bus_holder_enable_o     = vfc_r[`LVC_BIT_BUS_HOLD];
   assign pm_capability_visible_o = vfc_r[`LVC_BIT_PM_CAP];
   assign fast_eeprom_test_o      = vfc_r[`LVC_BIT_FAST_EE];

   // ----------------------------------------------------------------
   // test pin source select
   // ----------------------------------------------------------------
   // both sources come from outside this domain; a change is taken
   // only once the second and third stages agree
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         nand_sync_r       <= 3'h0;
         bist_sync_r       <= 3'h0;
         test_output_pin_o <= 1'b0;
      end else begin
         nand_sync_r <= {nand_sync_r[1:0], nand_tree_i};
         bist_sync_r <= {bist_sync_r[1:0], ram_bist_status_i};
         if (vfc_r[`LVC_BIT_TEST_SEL]) begin
            if (bist_sync_r[1] == bist_sync_r[2]) begin
               test_output_pin_o <= bist_sync_r[2];
            end
         end else begin
            if (nand_sync_r[1] == nand_sync_r[2]) begin
               test_output_pin_o <= nand_sync_r[2];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // cycle master absence
   // ----------------------------------------------------------------
   // the detector is off when disabled; the forced bit drives the result
   // on its own, so the disable bit cannot undo a forced condition
   lvc_master_det #(
      .LOST_LIMIT   (LOST_LIMIT)
   ) u_det (
      .core_clk_i   (core_clk_i),
      .nrst_i       (nrst_i),
      .enable_i     (~vfc_r[`LVC_BIT_DET_DIS]),
      .cycle_done_i (cycle_done_i),
      .cycle_lost_i (cycle_lost_i),
      .absent_o     (det_absent)
   );

   assign master_absent_o = vfc_r[`LVC_BIT_FORCE_ABS];

   // ----------------------------------------------------------------
   // enhanced phy feature enables
   // ----------------------------------------------------------------
   lvc_combine u_concat (
      .mode_i     (vfc_r[`LVC_BIT_MODE_HI:`LVC_BIT_MODE_LO]),
      .enhance_i  (vfc_r[`LVC_BIT_ENH_MIR]),
      .modifier_i (vfc_r[`LVC_BIT_ACK_CONCAT]),
      .result_o   (ack_concat_en_o)
   );

   lvc_combine u_accel (
      .mode_i     (vfc_r[`LVC_BIT_MODE_HI:`LVC_BIT_MODE_LO]),
      .enhance_i  (vfc_r[`LVC_BIT_ENH_MIR]),
      .modifier_i (vfc_r[`LVC_BIT_ACK_ACCEL]),
      .result_o   (ack_accel_en_o)
   );

   lvc_combine u_mspd (
      .mode_i     (vfc_r[`LVC_BIT_MODE_HI:`LVC_BIT_MODE_LO]),
      .enhance_i  (vfc_r[`LVC_BIT_ENH_MIR]),
      .modifier_i (vfc_r[`LVC_BIT_MULTISPD]),
      .result_o   (multispeed_en_o)
   );

   lvc_combine u_idle (
      .mode_i     (vfc_r[`LVC_BIT_MODE_HI:`LVC_BIT_MODE_LO]),
      .enhance_i  (vfc_r[`LVC_BIT_ENH_MIR]),
      .modifier_i (vfc_r[`LVC_BIT_IDLE_INS]),
      .result_o   (idle_insert_en_o)
   );

   // a received handshake loses the medium unless acceleration is on
   assign medium_lost_o = handshake_rx_i & ~ack_accel_en_o;

endmodule

// ===== lvc_defines.vh
// constants for the vendor feature control register block
`ifndef LVC_DEFINES_VH
`define LVC_DEFINES_VH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define LVC_VFC_OFFSET        6'h00
`define LVC_VFC_RESET         32'h0000_0000
`define LVC_VFC_WMASK         32'h003f_7ee0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LVC_BIT_BUS_HOLD      21
`define LVC_BIT_PM_CAP        20
`define LVC_BIT_TEST_SEL      19
`define LVC_BIT_FAST_EE       18
`define LVC_BIT_MODE_HI       17
`define LVC_BIT_MODE_LO       16
`define LVC_BIT_PROG_MIR      14
`define LVC_BIT_ENH_MIR       13
`define LVC_BIT_SPD_WP        12
`define LVC_BIT_DET_DIS       11
`define LVC_BIT_FORCE_ABS     10
`define LVC_BIT_ACK_CONCAT    9
`define LVC_BIT_ACK_ACCEL     7
`define LVC_BIT_MULTISPD      6
`define LVC_BIT_IDLE_INS      5

// ----------------------------------------------------------------
// combine modes and detector threshold
// ----------------------------------------------------------------
`define LVC_MODE_XOR          2'b00
`define LVC_MODE_AND          2'b01
`define LVC_MODE_OR           2'b10
`define LVC_MODE_XOR2         2'b11
`define LVC_LOST_LIMIT        8'hff

`endif

// ===== lvc_combine.v
// per-feature combiner of the phy enhancement enable and a modifier bit
`timescale 1ns/10ps
`include "lvc_defines.vh"

module lvc_combine (
   // controls
   input  wire [1:0] mode_i,
   input  wire       enhance_i,
   input  wire       modifier_i,
   // result
   output reg        result_o
);

   // ----------------------------------------------------------------
   // mode table
   // ----------------------------------------------------------------
   // both unused codes fall back to xor so no code is undefined
   always @* begin
      case (mode_i)
         `LVC_MODE_AND: result_o = enhance_i & modifier_i;
         `LVC_MODE_OR:  result_o = enhance_i | modifier_i;
         default:       result_o = enhance_i ^ modifier_i;
      endcase
   end

endmodule

// ===== lvc_master_det.v
// detector that flags an absent cycle master after a run of lost cycles
`timescale 1ns/10ps
`include "lvc_defines.vh"

module lvc_master_det #(
   parameter [7:0] LOST_LIMIT = `LVC_LOST_LIMIT
) (
   // clock and reset
   input  wire core_clk_i,
   input  wire nrst_i,
   // cycle events and control
   input  wire enable_i,
   input  wire cycle_done_i,
   input  wire cycle_lost_i,
   // conclusion pulse
   output reg  absent_o
);

   reg [7:0] lost_cnt_r;

   // ----------------------------------------------------------------
   // consecutive lost-cycle counter
   // ----------------------------------------------------------------
   // the counter saturates so a long outage yields a single pulse
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lost_cnt_r <= 8'h00;
         absent_o   <= 1'b0;
      end else begin
         absent_o <= 1'b0;
         if (!enable_i) begin
            lost_cnt_r <= 8'h00;
         end else if (cycle_lost_i) begin
            if (lost_cnt_r != LOST_LIMIT) begin
               lost_cnt_r <= lost_cnt_r + 8'h01;
               absent_o   <= (lost_cnt_r == LOST_LIMIT - 8'h01);
            end
         end else if (cycle_done_i) begin
            lost_cnt_r <= 8'h00;
         end
      end
   end

endmodule

// ===== lvc_vfc_chk_assertions.sv
// checker for the vendor feature control register
`timescale 1ns/10ps
`include "lvc_defines.vh"
module lvc_vfc_chk (
   // watched ports, packed to keep the checker short
   input wire        core_clk_i, nrst_i, vrw_sel_i, vrw_wr_i, ee_load_i, host_enh_wr_i,
   input wire [5:0]  vrw_addr_i,
   input wire [3:0]  vrw_be_i,
   input wire [31:0] vrw_wdata_i, vrw_rdata_o,
   input wire        host_prog_wr_i, host_prog_val_i, spd_wr_i, cycle_lost_i, handshake_rx_i,
   input wire [2:0]  spd_wdata_i, link_speed_field_o,
   input wire        host_ctrl_phy_program_enable_o, bus_holder_enable_o, pm_capability_visible_o,
   input wire        fast_eeprom_test_o, master_absent_o, ack_concat_en_o, ack_accel_en_o, medium_lost_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // host write to the mapped word with no eeprom load in the same cycle; the write would win in its byte lanes
   wire       wr0    = vrw_sel_i & vrw_wr_i & (vrw_addr_i == 6'h00) & ~ee_load_i;
   wire [2:0] wd_dir = {vrw_wdata_i[21], vrw_wdata_i[20], vrw_wdata_i[18]};
   wire [3:0] wd_cmb = {vrw_wdata_i[17:16], vrw_wdata_i[13], vrw_wdata_i[9]};
   // mode 01 is and, 10 is or, both other codes are xor
   function cmb(input [3:0] v);
      cmb = (v[3:2] == 2'b01) ? (v[1] & v[0]) : (v[3:2] == 2'b10) ? (v[1] | v[0]) : (v[1] ^ v[0]);
   endfunction
   AST_DIRECT: assert property (wr0 && vrw_be_i[2] |=>
      {bus_holder_enable_o, pm_capability_visible_o, fast_eeprom_test_o} == $past(wd_dir))
      else $error("direct bits do not follow host write");
   AST_COMBINE: assert property (wr0 && vrw_be_i[2] && vrw_be_i[1] && !host_enh_wr_i |=>
      ack_concat_en_o == cmb($past(wd_cmb)))
      else $error("combined enable wrong after write");
   AST_MEDIUM: assert property (medium_lost_o == (handshake_rx_i && !ack_accel_en_o))
      else $error("medium lost flag wrong");
   AST_MIRROR: assert property (host_prog_wr_i && !ee_load_i && !(vrw_sel_i && vrw_wr_i) |=>
      host_ctrl_phy_program_enable_o == $past(host_prog_val_i))
      else $error("program mirror missed host write");
   AST_SPEED: assert property ($changed(link_speed_field_o) |->
      $past(spd_wr_i) && link_speed_field_o == $past(spd_wdata_i))
      else $error("speed field changed without a write");
   AST_FORCE: assert property (wr0 && vrw_be_i[1] && vrw_wdata_i[10] |=> master_absent_o)
      else $error("forced absence not shown");
   AST_DETECT: assert property ($rose(master_absent_o) && !$past(vrw_sel_i) && !$past(ee_load_i) |->
      $past(cycle_lost_i, 2) || $past(cycle_lost_i, 3))
      else $error("absence raised without a lost cycle");
   AST_UNMAPPED: assert property (vrw_sel_i && !vrw_wr_i && vrw_addr_i != 6'h00 |->
      ##[1:2] vrw_rdata_o == 32'h0)
      else $error("unmapped read not zero");
   AST_RESERVED: assert property ((vrw_rdata_o & ~`LVC_VFC_WMASK) == 32'h0)
      else $error("reserved bits read nonzero");
   COV_WRITE: cover property (wr0 && vrw_be_i == 4'hf);
   COV_DETECT: cover property ($rose(master_absent_o) && !$past(vrw_sel_i));
   COV_HANDSHAKE: cover property (handshake_rx_i && !medium_lost_o);
endmodule
bind lvc_vendor_ctrl lvc_vfc_chk i_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .vrw_sel_i(vrw_sel_i),
   .vrw_wr_i(vrw_wr_i), .ee_load_i(ee_load_i), .host_enh_wr_i(host_enh_wr_i), .vrw_addr_i(vrw_addr_i),
   .vrw_be_i(vrw_be_i), .vrw_wdata_i(vrw_wdata_i), .vrw_rdata_o(vrw_rdata_o), .host_prog_wr_i(host_prog_wr_i),
   .host_prog_val_i(host_prog_val_i), .spd_wr_i(spd_wr_i), .cycle_lost_i(cycle_lost_i),
   .handshake_rx_i(handshake_rx_i), .spd_wdata_i(spd_wdata_i), .link_speed_field_o(link_speed_field_o),
   .host_ctrl_phy_program_enable_o(host_ctrl_phy_program_enable_o), .bus_holder_enable_o(bus_holder_enable_o),
   .pm_capability_visible_o(pm_capability_visible_o), .fast_eeprom_test_o(fast_eeprom_test_o),
   .master_absent_o(master_absent_o), .ack_concat_en_o(ack_concat_en_o), .ack_accel_en_o(ack_accel_en_o),
   .medium_lost_o(medium_lost_o));

// ===== lvc_tb.sv
// self-checking bench for the vendor feature control register
`timescale 1ns/10ps
`include "lvc_defines.vh"
module tb;
   reg         clk = 1'b0, rst_n = 1'b0, sel = 1'b0, wr = 1'b0, eel = 1'b0, pw = 1'b0, pv = 1'b0;
   reg         ew = 1'b0, ev = 1'b0, sw = 1'b0, cd = 1'b0, cl = 1'b0, hs = 1'b0, nt = 1'b0, rb = 1'b0;
   reg  [5:0]  adr = 6'h00;
   reg  [3:0]  be = 4'h0;
   reg  [31:0] wd = 32'h0, ed = 32'h0, d;
   reg  [2:0]  sd = 3'h0;
   wire [31:0] rd;
   wire [2:0]  spd;
   wire        pe, ee, bh, pm, tp, fe, ma, ac, aa, ms, ii, ml;
   integer     num_errors = 0, n_tests = 0, i, m, e, k;
   // free-running clock, 10 ns period
   always #5 clk = ~clk;
   // short lost-cycle threshold keeps the detector test brief
   lvc_vendor_ctrl #(.LOST_LIMIT(8'h04)) i_dut (.core_clk_i(clk), .nrst_i(rst_n), .vrw_sel_i(sel), .vrw_addr_i(adr),
      .vrw_wr_i(wr), .vrw_be_i(be), .vrw_wdata_i(wd), .vrw_rdata_o(rd), .ee_load_i(eel), .ee_data_i(ed),
      .host_prog_wr_i(pw), .host_prog_val_i(pv), .host_enh_wr_i(ew), .host_enh_val_i(ev),
      .host_ctrl_phy_program_enable_o(pe), .host_ctrl_phy_enhance_enable_o(ee), .spd_wr_i(sw), .spd_wdata_i(sd),
      .link_speed_field_o(spd), .cycle_done_i(cd), .cycle_lost_i(cl), .handshake_rx_i(hs), .nand_tree_i(nt),
      .ram_bist_status_i(rb), .bus_holder_enable_o(bh), .pm_capability_visible_o(pm), .test_output_pin_o(tp),
      .fast_eeprom_test_o(fe), .master_absent_o(ma), .ack_concat_en_o(ac), .ack_accel_en_o(aa),
      .multispeed_en_o(ms), .idle_insert_en_o(ii), .medium_lost_o(ml));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // one strobe per access; d holds the read data once the answer has settled
   task acc(input w, input [5:0] a, input [3:0] b, input [31:0] v);
      begin
         @(posedge clk);
         sel <= 1'b1;
         wr <= w;
         adr <= a;
         be <= b;
         wd <= v;
         @(posedge clk);
         sel <= 1'b0;
         @(posedge clk);
         #1 d = rd;
      end
   endtask
   // one-cycle pulse on the lost or good cycle input, then a quiet cycle
   task cyc(input l, input c);
      begin
         @(posedge clk);
         cl <= l;
         cd <= c;
         @(posedge clk);
         cl <= 1'b0;
         cd <= 1'b0;
      end
   endtask
   task spdw(input [2:0] v);
      begin
         @(posedge clk);
         sw <= 1'b1;
         sd <= v;
         @(posedge clk);
         sw <= 1'b0;
         @(posedge clk);
         #1;
      end
   endtask
   function cmb(input [1:0] md, input en, input x);
      cmb = (md == 2'b01) ? (en & x) : (md == 2'b10) ? (en | x) : (en ^ x);
   endfunction
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", n_tests, num_errors);
         if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      acc(1'b0, 6'h00, 4'h0, 32'h0);
      chk("reset word", `LVC_VFC_RESET, d);
      chk("reset outputs", 32'h0, {bh, pm, fe, ma, ac, aa, ms, ii, pe, ee});
      acc(1'b1, 6'h00, 4'hf, 32'hffff_ffff);
      acc(1'b0, 6'h00, 4'h0, 32'h0);
      chk("writable bits", `LVC_VFC_WMASK, d);
      chk("direct bits", 32'h3f, {bh, pm, fe, pe, ee, ma});
      acc(1'b1, 6'h00, 4'h1, 32'h0);
      acc(1'b1, 6'h04, 4'hf, 32'h0);
      acc(1'b0, 6'h00, 4'h0, 32'h0);
      chk("byte lane write", 32'h003f_7e00, d);
      acc(1'b0, 6'h04, 4'h0, 32'h0);
      chk("unmapped read", 32'h0, d);
      $display("test bus access done");
      // eeprom image lands in the writable bits only
      @(posedge clk);
      eel <= 1'b1;
      ed <= 32'haaaa_aaaa;
      @(posedge clk);
      eel <= 1'b0;
      acc(1'b0, 6'h00, 4'h0, 32'h0);
      chk("eeprom load", 32'h002a_2aa0, d);
      chk("eeprom outputs", 32'h4, {bh, pm, fe});
      rb <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("pin from self-test", 32'h1, tp);
      acc(1'b1, 6'h00, 4'hf, 32'h0);
      repeat (6) @(posedge clk);
      #1 chk("pin from nand tree", 32'h0, tp);
      $display("test eeprom and pin done");
      hs <= 1'b1;
      for (m = 0; m < 4; m = m + 1)
         for (e = 0; e < 2; e = e + 1)
            for (k = 0; k < 2; k = k + 1) begin
               acc(1'b1, 6'h00, 4'hf, (m << 16) | (e << 13) | (k << 9) | ((1 - k) << 7) | (k << 6) | ((1 - k) << 5));
               chk("combined", {cmb(m, e, k), cmb(m, e, 1 - k), cmb(m, e, k), cmb(m, e, 1 - k)},
                   {ac, aa, ms, ii});
               chk("medium lost", !cmb(m, e, 1 - k), ml);
               chk("enhance mirror", e, ee);
            end
      $display("test combine modes done");
      acc(1'b1, 6'h00, 4'hf, 32'h0);
      @(posedge clk);
      pw <= 1'b1;
      pv <= 1'b1;
      ew <= 1'b1;
      ev <= 1'b1;
      @(posedge clk);
      pw <= 1'b0;
      ew <= 1'b0;
      acc(1'b0, 6'h00, 4'h0, 32'h0);
      chk("mirrors", 32'h6000, d);
      spdw(3'h5);
      chk("speed open", 32'h5, spd);
      acc(1'b1, 6'h00, 4'hf, 32'h1000);
      spdw(3'h2);
      chk("speed protected", 32'h5, spd);
      $display("test mirrors and speed done");
      acc(1'b1, 6'h00, 4'hf, 32'h0);
      for (i = 0; i < 3; i = i + 1) cyc(1'b1, 1'b0);
      cyc(1'b0, 1'b1);
      for (i = 0; i < 3; i = i + 1) cyc(1'b1, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk("run restarted", 32'h0, ma);
      cyc(1'b1, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk("absence concluded", 32'h1, ma);
      acc(1'b1, 6'h00, 4'hf, 32'h800);
      for (i = 0; i < 6; i = i + 1) cyc(1'b1, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk("detector off", 32'h0, ma);
      acc(1'b1, 6'h00, 4'hf, 32'hc00);
      chk("forced absence", 32'h1, ma);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      acc(1'b0, 6'h00, 4'h0, 32'h0);
      chk("second reset", `LVC_VFC_RESET, d);
      $display("test detector and reset done");
      print_verdict;
   end
   // hang guard: a run this long counts as a mismatch
   initial begin
      #500000;
      num_errors = num_errors + 1;
      print_verdict;
   end
endmodule
